// *** verilog/mpt_cfg.svh ***
// offsets, field positions and reset values of the pwm pin and trigger block
`ifndef MPT_CFG_SVH
`define MPT_CFG_SVH

// ----------------------------------------
// global register byte addresses
// ----------------------------------------
`define MPT_OFF_MASTER 9'h000
`define MPT_OFF_DEVCFG 9'h004
`define MPT_OFF_PINOWN 9'h008
`define MPT_GEN_BASE 9'h040

// ----------------------------------------
// per-generator offsets, stride 0x20
// ----------------------------------------
`define MPT_GOFF_PHASE 5'h00
`define MPT_GOFF_TRIG 5'h04
`define MPT_GOFF_GENCTL 5'h08
`define MPT_GOFF_IOCTL 5'h0C
`define MPT_GOFF_COUNT 5'h10
`define MPT_GEN_FIRST 4'h2
`define MPT_GEN_LAST 4'hD

// ----------------------------------------
// field positions
// ----------------------------------------
`define MPT_EN_BIT 15
`define MPT_PRESC_LO 4
`define MPT_ARB_LO 18
`define MPT_LTB_BIT 9
`define MPT_MODE_LO 10
`define MPT_SEL_LO 8
`define MPT_MRG_BIT 7
`define MPT_SECIRQ_BIT 6
`define MPT_SDIV_LO 10

// ----------------------------------------
// reset values and fixed figures
// ----------------------------------------
`define MPT_RST_WORD 32'h0000_0000
`define MPT_RST_PHASE 16'h0000
`define MPT_MODE_INDEP 2'h3
`define MPT_PRESC_FULL 7'h7F

`endif

// *** verilog/mpt_pkg.sv ***
// types shared by the pwm pin and trigger block
package mpt_pkg;
    typedef logic [15:0] mpt_count_t; // phase, period and counter width
    typedef logic [1:0] mpt_mode_t; // output mode / half-cycle code
    typedef logic [3:0] mpt_div_t; // secondary divider ratio
endpackage

// *** verilog/mpt_gen_slice.sv ***
// one generator: phase delay or local time base, and secondary trigger path
`timescale 1ns/1ns
`include "mpt_cfg.svh"
module mpt_gen_slice import mpt_pkg::*; (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic tick,
    input wire logic masterStart,
    input wire mpt_count_t phaseIn,
    input wire logic ltb,
    input wire logic rawSec,
    input wire logic priEvent,
    input wire logic dualCycle,
    input wire logic countDir,
    input wire mpt_mode_t halfSel,
    input wire logic mrg,
    input wire logic secIrq,
    input wire mpt_div_t secDiv,
    output mpt_count_t localCount,
    output logic periodStart,
    output logic secTrig,
    output logic adcTrig,
    output logic irqEvent
);
    mpt_count_t phaseAct_ff; // value in force this period
    mpt_count_t count_ff; // local time base
    mpt_count_t dly_ff; // remaining phase delay in ticks
    logic wait_ff; // phase delay running
    logic start_ff;
    mpt_div_t divCnt_ff; // raw secondary events counted
    logic startNow;
    logic reached;
    logic halfOk;
    logic secEvent;
    logic sec_ff, adc_ff, irq_ff;

    // ----------------------------------------
    // period boundary
    // ----------------------------------------
    // ltb: free run, wraps after phaseAct ticks
    // otherwise start follows the master by phaseAct ticks
    always_comb begin
        if (ltb) begin
            // period below eight is unsupported, so no zero wrap guard
            startNow = tick && (count_ff >= phaseAct_ff - 16'h0001);
        end else begin
            startNow = (masterStart && phaseAct_ff == `MPT_RST_PHASE && !wait_ff) ||
                       (wait_ff && tick && dly_ff == 16'h0001);
        end
    end

    // new phase only at a boundary, never mid-period
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            phaseAct_ff <= `MPT_RST_PHASE;
        end else if (!enable || startNow) begin
            phaseAct_ff <= phaseIn;
        end
    end

    // phase delay after each master start
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !enable) begin
            wait_ff <= 1'b0;
            dly_ff <= `MPT_RST_PHASE;
        end else if (!ltb && masterStart && phaseAct_ff != `MPT_RST_PHASE) begin
            wait_ff <= 1'b1;
            dly_ff <= phaseAct_ff;
        end else if (wait_ff && tick) begin
            dly_ff <= dly_ff - 16'h0001;
            if (dly_ff == 16'h0001) begin
                wait_ff <= 1'b0;
            end
        end
    end

    // local counter restarts at each boundary, so duty and dead time shift too
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !enable) begin
            count_ff <= `MPT_RST_PHASE;
        end else if (startNow) begin
            count_ff <= `MPT_RST_PHASE;
        end else if (tick) begin
            count_ff <= count_ff + 16'h0001;
        end
    end

    // ----------------------------------------
    // secondary trigger
    // ----------------------------------------
    assign reached = (divCnt_ff == secDiv);

    // every raw match goes through the divider
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !enable) begin
            divCnt_ff <= 4'h0;
        end else if (rawSec) begin
            divCnt_ff <= reached ? 4'h0 : divCnt_ff + 4'h1;
        end
    end

    // half-cycle filter, only in dual-cycle modes
    always_comb begin
        halfOk = 1'b1;
        if (dualCycle) begin
            unique case (halfSel)
                2'b10: halfOk = !countDir;
                2'b01: halfOk = countDir;
                2'b00: halfOk = 1'b1;
                2'b11: halfOk = 1'b1;
            endcase
        end
    end

    assign secEvent = rawSec && reached && halfOk;

    // registered one-cycle event outputs
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !enable) begin
            start_ff <= 1'b0;
            sec_ff <= 1'b0;
            adc_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            start_ff <= startNow;
            sec_ff <= secEvent;
            adc_ff <= priEvent || (mrg && secEvent);
            irq_ff <= secIrq ? secEvent : (priEvent || (mrg && secEvent));
        end
    end

    assign localCount = count_ff;
    assign periodStart = start_ff;
    assign secTrig = sec_ff;
    assign adcTrig = adc_ff;
    assign irqEvent = irq_ff;
endmodule

// *** verilog/mpt_pin_trigger.sv ***
// pwm pin mapping, phase registers and secondary trigger control, twelve generators
//
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
`include "mpt_cfg.svh"
module mpt_pin_trigger import mpt_pkg::*; (
    input wire logic sys_clk,
    input wire logic rst_n,
    // register port
    input wire logic [8:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData,
    // master time base and generator logic, same clock
    input wire logic masterStart,
    input wire logic countDir,
    input wire logic dualCycle,
    input wire logic [11:0] priMatch,
    input wire logic [11:0] secMatch,
    input wire logic [11:0] genHighIn,
    input wire logic [11:0] genLowIn,
    // general i/o values for pins it owns
    input wire logic [11:0] gpioHighIn,
    input wire logic [7:0] gpioLowIn,
    // pins and events
    output logic [11:0] pwmHighOut,
    output logic [7:0] pwmLowOut,
    output logic [11:0] localStart,
    output logic [11:0] secTrigOut,
    output logic [11:0] adcTrigOut,
    output logic [11:0] irqEventOut,
    output logic [11:0] secDutyUse
);

    // ----------------------------------------
    // register storage
    // ----------------------------------------
    logic [31:0] master_ff; // enable 15, prescale 6:4
    logic [5:0] arb_ff; // device config bits 23:18
    logic [19:0] own_ff; // 11:0 high pins, 19:12 low pins
    mpt_count_t phase_ff [12]; // phase / local period
    logic [7:0] trig_ff [12]; // 13:6 of trigger control
    logic ltb_ff [12]; // generator control bit 9
    mpt_mode_t mode_ff [12]; // io control 11:10
    logic [31:0] rd_ff; // read data stands one cycle

    // address split
    logic [3:0] genSlot; // stride index, first gen at slot 2
    logic [3:0] genIdx; // generator 0..11
    logic [4:0] genOff; // offset inside a generator block
    logic genHit; // address falls in a generator block

    // per-generator results
    mpt_count_t localCount [12];
    logic [11:0] pwmHighRaw; // generator high outputs, passed through ungated
    logic [7:0] lowSel; // low pin source after arbitration

    // ----------------------------------------
    // prescaler
    // ----------------------------------------
    logic moduleEn; // master enable
    logic [2:0] prescSel; // divide by 2^sel
    logic [6:0] presc_ff;
    logic [6:0] prescMask;
    logic tick; // one count of every time base

    assign moduleEn = master_ff[`MPT_EN_BIT];
    assign prescSel = master_ff[`MPT_PRESC_LO +: 3];
    assign prescMask = 7'((8'h01 << prescSel) - 8'h01);
    // tick when the low sel bits are all ones; ratio 1 gives every cycle
    assign tick = moduleEn && ((presc_ff | ~prescMask) == `MPT_PRESC_FULL);

    // free-running prescale counter, cleared while disabled
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !moduleEn) begin
            presc_ff <= 7'h00;
        end else begin
            presc_ff <= presc_ff + 7'h01;
        end
    end

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    assign genSlot = regAddr[8:5];
    assign genOff = regAddr[4:0];
    assign genHit = (genSlot >= `MPT_GEN_FIRST) && (genSlot <= `MPT_GEN_LAST);
    assign genIdx = genSlot - `MPT_GEN_FIRST;

    // ----------------------------------------
    // global register writes
    // ----------------------------------------
    // only enable and prescale bits are kept; others read zero
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            master_ff <= `MPT_RST_WORD;
        end else if (regWr && regAddr == `MPT_OFF_MASTER) begin
            master_ff <= regWrData & 32'h0000_8070;
        end
    end

    // arbitration bits in the device config word
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            arb_ff <= 6'h00;
        end else if (regWr && regAddr == `MPT_OFF_DEVCFG) begin
            arb_ff <= regWrData[`MPT_ARB_LO +: 6];
        end
    end

    // pin ownership: set bit gives the pin to the pwm
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            own_ff <= 20'h0_0000;
        end else if (regWr && regAddr == `MPT_OFF_PINOWN) begin
            own_ff <= regWrData[19:0];
        end
    end

    // ----------------------------------------
    // per-generator register writes
    // ----------------------------------------
    // trigger bits are taken whenever written; software is to
    // touch them only with the module disabled, so no shadowing
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < 12; i++) begin
                phase_ff[i] <= `MPT_RST_PHASE;
                trig_ff[i] <= 8'h00;
                ltb_ff[i] <= 1'b0;
                mode_ff[i] <= 2'h0;
            end
        end else if (regWr && genHit) begin
            unique case (genOff)
                `MPT_GOFF_PHASE: begin
                    // slice takes it at the next boundary
                    phase_ff[genIdx] <= regWrData[15:0];
                end
                `MPT_GOFF_TRIG: begin
                    trig_ff[genIdx] <= regWrData[13:6];
                end
                `MPT_GOFF_GENCTL: begin
                    ltb_ff[genIdx] <= regWrData[`MPT_LTB_BIT];
                end
                `MPT_GOFF_IOCTL: begin
                    mode_ff[genIdx] <= regWrData[`MPT_MODE_LO +: 2];
                end
                default: begin
                    // counter readback and holes: write ignored
                end
            endcase
        end
    end

    // ----------------------------------------
    // read path
    // ----------------------------------------
    // data stand in the cycle after the strobe, zero otherwise
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !regRd) begin
            rd_ff <= `MPT_RST_WORD;
        end else if (genHit) begin
            unique case (genOff)
                `MPT_GOFF_PHASE: begin
                    rd_ff <= {16'h0000, phase_ff[genIdx]};
                end
                `MPT_GOFF_TRIG: begin
                    // bits 5:0 and above 13 unimplemented
                    rd_ff <= {18'h0_0000, trig_ff[genIdx], 6'h00};
                end
                `MPT_GOFF_GENCTL: begin
                    rd_ff <= 32'(ltb_ff[genIdx]) << `MPT_LTB_BIT;
                end
                `MPT_GOFF_IOCTL: begin
                    rd_ff <= 32'(mode_ff[genIdx]) << `MPT_MODE_LO;
                end
                `MPT_GOFF_COUNT: begin
                    rd_ff <= {16'h0000, localCount[genIdx]};
                end
                default: begin
                    rd_ff <= `MPT_RST_WORD; // hole reads zero
                end
            endcase
        end else begin
            unique case (regAddr)
                `MPT_OFF_MASTER: rd_ff <= master_ff;
                `MPT_OFF_DEVCFG: rd_ff <= 32'(arb_ff) << `MPT_ARB_LO;
                `MPT_OFF_PINOWN: rd_ff <= {12'h000, own_ff};
                default: rd_ff <= `MPT_RST_WORD; // unmapped reads zero
            endcase
        end
    end

    assign regRdData = rd_ff;

    // ----------------------------------------
    // generator slices
    // ----------------------------------------
    for (genvar g = 0; g < 12; g++) begin : gen_slice
        mpt_gen_slice u_slice (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .enable(moduleEn),
            .tick(tick),
            .masterStart(masterStart),
            .phaseIn(phase_ff[g]),
            .ltb(ltb_ff[g]),
            .rawSec(secMatch[g]),
            .priEvent(priMatch[g]),
            .dualCycle(dualCycle),
            .countDir(countDir),
            .halfSel(trig_ff[g][3:2]),
            .mrg(trig_ff[g][1]),
            .secIrq(trig_ff[g][0]),
            .secDiv(trig_ff[g][7:4]),
            .localCount(localCount[g]),
            .periodStart(localStart[g]),
            .secTrig(secTrigOut[g]),
            .adcTrig(adcTrigOut[g]),
            .irqEvent(irqEventOut[g])
        );
        // secondary duty steers the low side only when independent
        assign secDutyUse[g] = (mode_ff[g] == `MPT_MODE_INDEP);
        assign pwmHighRaw[g] = genHighIn[g];
    end

    // ----------------------------------------
    // low pin arbitration
    // ----------------------------------------
    // low pins 0..5 are generators 1..6, pins 6..7 generators 11..12
    always_comb begin
        for (int p = 0; p < 4; p++) begin
            // generators 7..10 have no low pin of their own
            lowSel[p] = arb_ff[p] ? pwmHighRaw[6 + p] : genLowIn[p];
        end
        for (int p = 4; p < 6; p++) begin
            lowSel[p] = arb_ff[p] ? pwmHighRaw[6 + p] : genLowIn[p];
        end
        lowSel[6] = genLowIn[10];
        lowSel[7] = genLowIn[11];
    end

    // ----------------------------------------
    // pin drivers
    // ----------------------------------------
    // registered so pins never glitch on a config write;
    // costs one cycle of latency against the generators
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pwmHighOut <= 12'h000;
            pwmLowOut <= 8'h00;
        end else begin
            // ownership bit decides pwm versus general i/o
            pwmHighOut <= (own_ff[11:0] & pwmHighRaw) | (~own_ff[11:0] & gpioHighIn);
            pwmLowOut <= (own_ff[19:12] & lowSel) | (~own_ff[19:12] & gpioLowIn);
        end
    end

endmodule

// *** dv/mpt_pin_trigger_asserts.sv ***
// concurrent checks on the ports of the pwm pin and trigger block
`timescale 1ns/1ns
`include "mpt_cfg.svh"
module mpt_pin_trigger_chk (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [8:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [31:0] regRdData,
    input wire logic [11:0] priMatch,
    input wire logic [11:0] secMatch,
    input wire logic [11:0] genHighIn,
    input wire logic [11:0] genLowIn,
    input wire logic [11:0] gpioHighIn,
    input wire logic [7:0] gpioLowIn,
    input wire logic [11:0] pwmHighOut,
    input wire logic [7:0] pwmLowOut,
    input wire logic [11:0] localStart,
    input wire logic [11:0] secTrigOut,
    input wire logic [11:0] adcTrigOut,
    input wire logic [11:0] irqEventOut
);
    // ----------------------------------------
    // shadow of the registers the pins and the event outputs depend on
    // ----------------------------------------
    logic [19:0] pinOwn_ff; // 1 = pwm owns the pin
    logic [5:0] arbSel_ff; // low pin source picks
    logic enable_ff; // module enable copy
    logic [7:0] lowSrc; // pwm value offered to low pins
    logic [11:0] highExp; // expected next high pins
    logic [7:0] lowExp; // expected next low pins
    // one process: the three shadows share the same write decode
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pinOwn_ff <= 20'h0_0000;
            arbSel_ff <= 6'h00;
            enable_ff <= 1'b0;
        end else if (regWr) begin
            if (regAddr == `MPT_OFF_PINOWN) pinOwn_ff <= regWrData[19:0];
            if (regAddr == `MPT_OFF_DEVCFG) arbSel_ff <= regWrData[23:18];
            if (regAddr == `MPT_OFF_MASTER) enable_ff <= regWrData[15];
        end
    end
    assign lowSrc = {genLowIn[11:10], (genHighIn[11:6] & arbSel_ff) | (genLowIn[5:0] & ~arbSel_ff)};
    assign highExp = (genHighIn & pinOwn_ff[11:0]) | (gpioHighIn & ~pinOwn_ff[11:0]);
    assign lowExp = (lowSrc & pinOwn_ff[19:12]) | (gpioLowIn & ~pinOwn_ff[19:12]);
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_rd_idle_zero: assert property (!$past(regRd) |-> regRdData == 32'h0000_0000) else $error("read data outside read slot");
    a_phase_upper_zero: assert property ($past(regRd) && $past(regAddr) >= `MPT_GEN_BASE &&
        ($past(regAddr) & 9'h01F) == 9'h000 |-> regRdData[31:16] == 16'h0000) else $error("phase upper half set");
    a_trig_low_zero: assert property ($past(regRd) && $past(regAddr) >= `MPT_GEN_BASE &&
        ($past(regAddr) & 9'h01F) == 9'h004 |-> regRdData[5:0] == 6'h00) else $error("trigger low bits set");
    a_high_pins_map: assert property ($past(rst_n) |-> pwmHighOut == $past(highExp)) else $error("high pin value");
    a_low_pins_map: assert property ($past(rst_n) |-> pwmLowOut == $past(lowExp)) else $error("low pin value");
    a_sec_has_cause: assert property ((secTrigOut & ~$past(secMatch)) == 12'h000) else $error("stray sec trigger");
    a_adc_has_cause: assert property ((adcTrigOut & ~($past(priMatch) | $past(secMatch))) == 12'h000)
        else $error("stray adc trigger");
    a_irq_has_cause: assert property ((irqEventOut & ~($past(priMatch) | $past(secMatch))) == 12'h000)
        else $error("stray interrupt event");
    a_off_stays_quiet: assert property (!enable_ff && !$past(enable_ff) |->
        (secTrigOut | adcTrigOut | irqEventOut | localStart) == 12'h000) else $error("events while disabled");
    c_sec_trig: cover property (secTrigOut[0]);
    c_local_start: cover property (localStart[1]);
    c_read_data: cover property (regRd ##1 regRdData != 32'h0000_0000);
endmodule
bind mpt_pin_trigger mpt_pin_trigger_chk mpt_pin_trigger_chk_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .priMatch(priMatch), .secMatch(secMatch), .genHighIn(genHighIn), .genLowIn(genLowIn),
    .gpioHighIn(gpioHighIn), .gpioLowIn(gpioLowIn), .pwmHighOut(pwmHighOut), .pwmLowOut(pwmLowOut),
    .localStart(localStart), .secTrigOut(secTrigOut), .adcTrigOut(adcTrigOut), .irqEventOut(irqEventOut));

// *** dv/mpt_load_model.sv ***
// power stage and adc input stand-in, counts conversions of generator one
`timescale 1ns/1ns
module mpt_load_model (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [11:0] pwmHighOut,
    input wire logic [7:0] pwmLowOut,
    input wire logic [11:0] adcTrigOut,
    output int adcCount
);
    // switches only load the pins; the adc starts once per trigger pulse
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            adcCount <= 0;
        end else if (adcTrigOut[0]) begin
            adcCount <= adcCount + 1;
        end
    end
endmodule

// *** dv/testbench.sv ***
// self-checking bench for the pwm pin and trigger block
`timescale 1ns/1ns
`include "mpt_cfg.svh"
module testbench;
    import mpt_pkg::*;
    // ----------------------------------------
    // stimulus, outputs and bookkeeping
    // ----------------------------------------
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [8:0] regAddr = 9'h000;
    logic [31:0] regWrData = 32'h0000_0000;
    logic regWr = 1'b0, regRd = 1'b0, masterStart = 1'b0, countDir = 1'b0, dualCycle = 1'b0;
    logic [11:0] priMatch = 12'h000, secMatch = 12'h000, genHighIn = 12'h000, genLowIn = 12'h000;
    logic [11:0] gpioHighIn = 12'h000;
    logic [7:0] gpioLowIn = 8'h00, pwmLowOut, lowSrc;
    logic [31:0] regRdData;
    logic [11:0] pwmHighOut, localStart, secTrigOut, adcTrigOut, irqEventOut, secDutyUse;
    logic [19:0] own; // ownership word under test
    logic [5:0] arb; // arbitration word under test
    int checks = 0, fail_count = 0, cycles = 0, adcCount, adcTotal = 0, n, c;
    integer seed = 32'ha5f7;
    always #5 sys_clk = ~sys_clk;
    mpt_pin_trigger mpt_pin_trigger_inst (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .masterStart(masterStart),
        .countDir(countDir), .dualCycle(dualCycle), .priMatch(priMatch), .secMatch(secMatch),
        .genHighIn(genHighIn), .genLowIn(genLowIn), .gpioHighIn(gpioHighIn), .gpioLowIn(gpioLowIn),
        .pwmHighOut(pwmHighOut), .pwmLowOut(pwmLowOut), .localStart(localStart), .secTrigOut(secTrigOut),
        .adcTrigOut(adcTrigOut), .irqEventOut(irqEventOut), .secDutyUse(secDutyUse));
    mpt_load_model mpt_load_model_inst (.sys_clk(sys_clk), .rst_n(rst_n), .pwmHighOut(pwmHighOut),
        .pwmLowOut(pwmLowOut), .adcTrigOut(adcTrigOut), .adcCount(adcCount));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic end_of_test;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [8:0] a, input logic [31:0] exp, input string what);
        @(posedge sys_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1;
        chk(what, exp, regRdData);
    endtask
    // edges until the next period boundary of one generator, bounded
    task automatic gap(input int idx, output int cnt);
        cnt = 0;
        do begin
            @(posedge sys_clk);
            #1;
            cnt++;
        end while (localStart[idx] !== 1'b1 && cnt < 200);
    endtask
    // random match pulses on generator one, reference divider kept in an int
    task automatic pulse(input int num, input int sel, input int div, input bit mrg, input bit sis);
        bit p, s, dc, dir, pass, adc;
        int cnt;
        cnt = 0;
        repeat (num) begin
            p = 1'($random(seed));
            s = 1'($random(seed)) | 1'($random(seed));
            dc = 1'($random(seed));
            dir = 1'($random(seed));
            @(posedge sys_clk);
            priMatch <= {11'h000, p};
            secMatch <= {11'h000, s};
            dualCycle <= dc;
            countDir <= dir;
            pass = 1'b0;
            if (s) cnt++;
            if (s && cnt > div) begin
                pass = 1'b1;
                cnt = 0;
            end
            if (dc && sel == 1) pass &= dir;
            if (dc && sel == 2) pass &= !dir;
            adc = p | (mrg & pass);
            adcTotal += adc;
            @(posedge sys_clk);
            priMatch <= 12'h000;
            secMatch <= 12'h000;
            #1;
            chk("sec trigger", 32'(pass), 32'(secTrigOut));
            chk("adc trigger", 32'(adc), 32'(adcTrigOut));
            chk("irq event", 32'(sis ? pass : adc), 32'(irqEventOut));
        end
    endtask
    // cycle ceiling, far above the fewer than one thousand cycles the run needs
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            end_of_test;
        end
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(9'h040, 32'h0000_0000, "phase reset");
        rd(9'h044, 32'h0000_0000, "trigger reset");
        rd(9'h03C, 32'h0000_0000, "unmapped");
        wr(9'h1A0, 32'hFFFF_1234);
        rd(9'h1A0, 32'h0000_1234, "phase word");
        wr(9'h1A4, 32'hFFFF_FFFF);
        rd(9'h1A4, 32'h0000_3FC0, "trigger word");
        wr(9'h1A0, 32'h0000_0000);
        wr(9'h1A4, 32'h0000_0000);
        for (c = 0; c < 6; c++) begin
            own = 20'($random(seed));
            arb = 6'($random(seed));
            wr(`MPT_OFF_PINOWN, 32'(own));
            wr(`MPT_OFF_DEVCFG, 32'(arb) << 18);
            @(posedge sys_clk);
            genHighIn <= 12'($random(seed));
            genLowIn <= 12'($random(seed));
            gpioHighIn <= 12'($random(seed));
            gpioLowIn <= 8'($random(seed));
            repeat (2) @(posedge sys_clk);
            #1;
            lowSrc = {genLowIn[11:10], (genHighIn[11:6] & arb) | (genLowIn[5:0] & ~arb)};
            chk("high pins", 32'((genHighIn & own[11:0]) | (gpioHighIn & ~own[11:0])), 32'(pwmHighOut));
            chk("low pins", 32'((lowSrc & own[19:12]) | (gpioLowIn & ~own[19:12])), 32'(pwmLowOut));
        end
        // trigger bits only change while the module is off
        for (c = 0; c < 18; c++) begin
            wr(`MPT_OFF_MASTER, 32'h0000_0000);
            wr(9'h044, 32'(((c >= 16 ? 2 : 0) << 10) | ((c % 4) << 8) | (((c >> 2) & 1) << 7) | (((c >> 3) & 1) << 6)));
            wr(`MPT_OFF_MASTER, 32'h0000_8000);
            pulse(10, c % 4, c >= 16 ? 2 : 0, 1'((c >> 2) & 1), 1'((c >> 3) & 1));
        end
        wr(`MPT_OFF_MASTER, 32'h0000_0000);
        wr(9'h068, 32'h0000_0200);
        wr(9'h060, 32'h0000_0008);
        wr(`MPT_OFF_MASTER, 32'h0000_8000);
        gap(1, n);
        gap(1, n);
        chk("local period", 32'(8), 32'(n));
        wr(9'h060, 32'h0000_000C);
        gap(1, n);
        chk("period in flight", 32'(6), 32'(n));
        gap(1, n);
        chk("period new", 32'(12), 32'(n));
        wr(`MPT_OFF_MASTER, 32'h0000_8010);
        gap(1, n);
        gap(1, n);
        chk("period prescaled", 32'(24), 32'(n));
        wr(`MPT_OFF_MASTER, 32'h0000_8000);
        wr(9'h040, 32'h0000_0003);
        @(posedge sys_clk);
        masterStart <= 1'b1;
        @(posedge sys_clk);
        masterStart <= 1'b0;
        #1;
        chk("master start", 32'h0000_0FFD, 32'(localStart & 12'hFFD));
        @(posedge sys_clk);
        masterStart <= 1'b1;
        @(posedge sys_clk);
        masterStart <= 1'b0;
        gap(0, n);
        chk("phase delay", 32'(3), 32'(n));
        wr(9'h0CC, 32'h0000_0C00);
        #1;
        chk("duty use indep", 32'h0000_0010, 32'(secDutyUse));
        wr(9'h0CC, 32'h0000_0800);
        #1;
        chk("duty use push", 32'h0000_0000, 32'(secDutyUse));
        chk("adc count", 32'(adcTotal), 32'(adcCount));
        end_of_test;
    end
endmodule
